// *** logic/lsp_consts.svh ***
/*
 * Timing and layout constants of the lamp switch PWM and input control.
 * Assumes a 250 MHz core clock; times are in ns and counts derive from them.
 */
`ifndef LSP_CONSTS_SVH
`define LSP_CONSTS_SVH

`define LSP_CLK_NS        4
`define LSP_CAL_MIN_NS    20000
`define LSP_CAL_MAX_NS    200000
`define LSP_FAIL_SLOW_NS  500000
`define LSP_FAIL_FAST_NS  5000
`define LSP_TOGGLE_NS     250000000
`define LSP_PWM_DEF_HZ    120
`define LSP_PWM_STEPS     256
`define LSP_NS_PER_S      1000000000
`define LSP_CAL_SHIFT     3
`define LSP_WORD_BITS     16
`define LSP_DUTY_BITS     8
`define LSP_DUTY_FULL     8'hFF
`define LSP_SENSE_TEMP    3'h4
`define LSP_SENSE_CHANS   3'h4
`define LSP_SY_CLK_IN     0
`define LSP_SY_SCLK       4
`define LSP_SY_CS_B       5
`define LSP_SY_SI         6

`endif

// *** logic/lsp_pkg.sv ***
/*
 * Types of the lamp switch PWM and input control.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package lsp_pkg;
    typedef enum logic {
        LSP_CLK_EXT,
        LSP_CLK_INT
    } lsp_clk_src_t;
endpackage
`default_nettype wire

// *** logic/lsp_ctrl.sv ***
/*
 * Lamp switch control: PWM clocking, clock-fail check, direct inputs,
 * serial word transfer and current-sense source selection.
 * Assumes pins arrive asynchronously; the host keeps its own timing.
 */
`include "lsp_consts.svh"
`default_nettype none

// Behaviour
// - Clock-fail detector armed only when PWM enabled and external clock chosen.
// - Flag external clock failed below about 2 kHz or above about 200 kHz.
// - Uncalibrated PWM period comes from internal oscillator, nominally 120 Hz.
// - Chip-select low pulses of 20 to 200 us calibrate the oscillator.
// - Calibrated PWM frequency is accurate within ten percent.
// - PWM generator reaches output frequencies up to 1 kHz.
// - Duty covers fully on, fully off and ratios in between.
// - Direct-input toggle timeout of nominally 250 ms judges toggling.
// - Sense output carries chosen output current or temperature, set by software.
// - Sense output goes high impedance when commanded.
// - Any asserted direct input wakes the device.
// - Each direct input drives its matching high-side output unless PWM is enabled and selected for that output.
// - External PWM clock is taken from the first direct input.
// - Word loads on chip-select rise; status captured on chip-select fall.
// - Words are 16 bits, MSB first, input sampled on serial clock fall.
module lsp_ctrl #(
    parameter int CAL_MIN_CYC  = (`LSP_CAL_MIN_NS + `LSP_CLK_NS - 1)
                                 / `LSP_CLK_NS,
    parameter int CAL_MAX_CYC  = `LSP_CAL_MAX_NS / `LSP_CLK_NS,
    parameter int FAIL_SLOW_CYC = `LSP_FAIL_SLOW_NS / `LSP_CLK_NS,
    parameter int TOGGLE_CYC   = `LSP_TOGGLE_NS / `LSP_CLK_NS,
    parameter int DEF_TICK_CYC = `LSP_NS_PER_S / (`LSP_PWM_DEF_HZ
                                 * `LSP_PWM_STEPS * `LSP_CLK_NS),
    parameter int CHANS        = 4
) (
    input  wire logic                     core_clk_i,
    input  wire logic                     rst_b_i,
    input  wire logic [CHANS-1:0]         direct_inputs_i,
    input  wire logic                     spi_sclk_i,
    input  wire logic                     spi_cs_b_i,
    input  wire logic                     spi_si_i,
    output logic                          spi_so_o,
    output logic                          spi_so_oe_b_o,
    output logic [`LSP_WORD_BITS-1:0]     spi_word_o,
    output logic                          spi_load_o,
    input  wire logic [`LSP_WORD_BITS-1:0] status_i,
    input  wire logic                     pwm_en_i,
    input  wire logic                     clock_sel_i,
    input  wire logic [CHANS-1:0]         pwm_sel_i,
    input  wire logic [CHANS*`LSP_DUTY_BITS-1:0] duty_i,
    input  wire logic [2:0]               sense_src_i,
    input  wire logic                     sense_hiz_i,
    output logic [CHANS-1:0]              high_side_outputs_o,
    output logic                          clk_fail_o,
    output logic                          cal_done_o,
    output logic [CHANS-1:0]              toggling_o,
    output logic                          wake_o,
    output logic [CHANS-1:0]              sense_chan_o,
    output logic                          sense_temp_o,
    output logic                          current_sense_output_oe_b_o
);
    localparam int FAIL_FAST_CYC = `LSP_FAIL_FAST_NS / `LSP_CLK_NS;
    localparam int SY = CHANS + 3;
    localparam int CW = $clog2(CAL_MAX_CYC + 2);
    // The tick counter must hold both the default and any calibrated length.
    localparam int TICK_MAX = (DEF_TICK_CYC > (CAL_MAX_CYC >> `LSP_CAL_SHIFT))
                            ? DEF_TICK_CYC : (CAL_MAX_CYC >> `LSP_CAL_SHIFT);
    localparam int TW = $clog2(TICK_MAX + 1);
    localparam int PW = $clog2(FAIL_SLOW_CYC + 2);
    localparam int GW = $clog2(TOGGLE_CYC + 1);
    localparam logic [4:0] WORD = 5'(`LSP_WORD_BITS);

    // Two-stage synchronisers, third stage only for edge detection.
    logic [SY-1:0] sy1_ff, sy2_ff, sy3_ff, rise, fall;
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            sy1_ff <= '0;
            sy2_ff <= '0;
            sy3_ff <= '0;
        end else begin
            sy1_ff <= {spi_si_i, spi_cs_b_i, spi_sclk_i, direct_inputs_i};
            sy2_ff <= sy1_ff;
            sy3_ff <= sy2_ff;
        end
    end
    assign rise = sy2_ff & ~sy3_ff;
    assign fall = ~sy2_ff & sy3_ff;

    logic [CHANS-1:0] in_s;
    logic             sclk_fall, sclk_rise, cs_b, cs_fall, cs_rise, si;
    assign in_s      = sy2_ff[CHANS-1:0];
    assign sclk_fall = fall[`LSP_SY_SCLK];
    assign sclk_rise = rise[`LSP_SY_SCLK];
    assign cs_b      = sy2_ff[`LSP_SY_CS_B];
    assign cs_fall   = fall[`LSP_SY_CS_B];
    assign cs_rise   = rise[`LSP_SY_CS_B];
    assign si        = sy2_ff[`LSP_SY_SI];

    // Serial word transfer.
    logic [`LSP_WORD_BITS-1:0] sh_ff, nxt_sh, word_ff, nxt_word;
    logic [4:0]                bits_ff, nxt_bits;
    logic                      so_ff, nxt_so, load_ff, nxt_load;
    always_comb begin
        nxt_sh   = sh_ff;
        nxt_bits = bits_ff;
        nxt_so   = so_ff;
        nxt_word = word_ff;
        nxt_load = 1'b0;
        if (cs_fall) begin
            nxt_sh   = status_i;
            nxt_bits = '0;
            nxt_so   = status_i[`LSP_WORD_BITS-1];
        end else if (!cs_b) begin
            if (sclk_fall) begin
                nxt_sh = {sh_ff[`LSP_WORD_BITS-2:0], si};
                if (bits_ff != WORD) begin
                    nxt_bits = bits_ff + 5'h01;
                end
            end
            if (sclk_rise) begin
                nxt_so = sh_ff[`LSP_WORD_BITS-1];
            end
        end
        if (cs_rise && bits_ff == WORD) begin
            nxt_word = sh_ff;
            nxt_load = 1'b1;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            sh_ff   <= '0;
            bits_ff <= '0;
            so_ff   <= 1'b0;
            word_ff <= '0;
            load_ff <= 1'b0;
        end else begin
            sh_ff   <= nxt_sh;
            bits_ff <= nxt_bits;
            so_ff   <= nxt_so;
            word_ff <= nxt_word;
            load_ff <= nxt_load;
        end
    end
    assign spi_so_o      = so_ff;
    assign spi_so_oe_b_o = cs_b;
    assign spi_word_o    = word_ff;
    assign spi_load_o    = load_ff;

    // Calibration: a clockless select pulse sets the internal tick length.
    logic [CW-1:0] cal_ff, nxt_cal;
    logic [TW-1:0] tick_len_ff, nxt_tick_len;
    logic          cal_done_ff, nxt_cal_done;
    always_comb begin
        nxt_cal      = cal_ff;
        nxt_tick_len = tick_len_ff;
        nxt_cal_done = cal_done_ff;
        if (cs_fall) begin
            nxt_cal = '0;
        end else if (!cs_b && cal_ff <= CW'(CAL_MAX_CYC)) begin
            nxt_cal = cal_ff + CW'(1);
        end
        if (cs_rise && bits_ff == 5'h00 && cal_ff >= CW'(CAL_MIN_CYC)
            && cal_ff <= CW'(CAL_MAX_CYC)) begin
            nxt_tick_len = TW'(cal_ff >> `LSP_CAL_SHIFT);
            nxt_cal_done = 1'b1;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            cal_ff      <= '0;
            tick_len_ff <= TW'(DEF_TICK_CYC);
            cal_done_ff <= 1'b0;
        end else begin
            cal_ff      <= nxt_cal;
            tick_len_ff <= nxt_tick_len;
            cal_done_ff <= nxt_cal_done;
        end
    end
    assign cal_done_o = cal_done_ff;

    // PWM time base and generator.
    lsp_pkg::lsp_clk_src_t src;
    logic                  ext, tick;
    logic [TW-1:0]         pre_ff, nxt_pre;
    logic [7:0]            pcnt_ff, nxt_pcnt;
    logic [CHANS-1:0]      hs_ff, nxt_hs;
    assign src  = clock_sel_i ? lsp_pkg::LSP_CLK_INT : lsp_pkg::LSP_CLK_EXT;
    assign ext  = pwm_en_i && src == lsp_pkg::LSP_CLK_EXT;
    assign tick = ext ? rise[`LSP_SY_CLK_IN]
                      : (pre_ff >= tick_len_ff - TW'(1));
    always_comb begin
        nxt_pre  = (tick || ext) ? '0 : pre_ff + TW'(1);
        nxt_pcnt = !pwm_en_i ? 8'h00 : (tick ? pcnt_ff + 8'h01 : pcnt_ff);
        for (int i = 0; i < CHANS; i++) begin
            if (pwm_en_i && pwm_sel_i[i]) begin
                nxt_hs[i] = duty_i[i*`LSP_DUTY_BITS +: `LSP_DUTY_BITS]
                            == `LSP_DUTY_FULL
                         || pcnt_ff < duty_i[i*`LSP_DUTY_BITS
                                             +: `LSP_DUTY_BITS];
            end else begin
                nxt_hs[i] = in_s[i];
            end
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            pre_ff  <= '0;
            pcnt_ff <= 8'h00;
            hs_ff   <= '0;
        end else begin
            pre_ff  <= nxt_pre;
            pcnt_ff <= nxt_pcnt;
            hs_ff   <= nxt_hs;
        end
    end
    assign high_side_outputs_o = hs_ff;

    // External clock failure check by period measurement.
    logic [PW-1:0] per_ff, nxt_per;
    logic          seen_ff, nxt_seen, fail_ff, nxt_fail;
    always_comb begin
        nxt_per  = per_ff;
        nxt_seen = seen_ff;
        nxt_fail = fail_ff;
        if (!ext) begin
            nxt_per  = '0;
            nxt_seen = 1'b0;
            nxt_fail = 1'b0;
        end else if (rise[`LSP_SY_CLK_IN]) begin
            nxt_per  = '0;
            nxt_seen = 1'b1;
            nxt_fail = seen_ff && per_ff < PW'(FAIL_FAST_CYC);
        end else begin
            if (per_ff <= PW'(FAIL_SLOW_CYC)) begin
                nxt_per = per_ff + PW'(1);
            end else begin
                nxt_fail = 1'b1;
            end
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            per_ff  <= '0;
            seen_ff <= 1'b0;
            fail_ff <= 1'b0;
        end else begin
            per_ff  <= nxt_per;
            seen_ff <= nxt_seen;
            fail_ff <= nxt_fail;
        end
    end
    assign clk_fail_o = fail_ff;

    // Toggle timeout per direct input.
    for (genvar g = 0; g < CHANS; g++) begin : g_tog
        logic [GW-1:0] tc_ff, nxt_tc;
        logic          tg_ff, nxt_tg;
        always_comb begin
            nxt_tc = tc_ff;
            nxt_tg = tg_ff;
            if (rise[g] || fall[g]) begin
                nxt_tc = '0;
                nxt_tg = 1'b1;
            end else if (tc_ff < GW'(TOGGLE_CYC)) begin
                nxt_tc = tc_ff + GW'(1);
            end else begin
                nxt_tg = 1'b0;
            end
        end
        always_ff @(posedge core_clk_i) begin
            if (!rst_b_i) begin
                tc_ff <= '0;
                tg_ff <= 1'b0;
            end else begin
                tc_ff <= nxt_tc;
                tg_ff <= nxt_tg;
            end
        end
        assign toggling_o[g] = tg_ff;
    end

    // Wake request and current-sense source selection.
    logic [CHANS-1:0] sch_ff, nxt_sch;
    logic             stemp_ff, nxt_stemp, soe_b_ff, nxt_soe_b, wake_ff;
    always_comb begin
        nxt_sch   = '0;
        nxt_stemp = sense_src_i == `LSP_SENSE_TEMP;
        nxt_soe_b = sense_hiz_i;
        if (sense_src_i < `LSP_SENSE_CHANS) begin
            nxt_sch[sense_src_i[1:0]] = 1'b1;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            sch_ff   <= '0;
            stemp_ff <= 1'b0;
            soe_b_ff <= 1'b1;
            wake_ff  <= 1'b0;
        end else begin
            sch_ff   <= nxt_sch;
            stemp_ff <= nxt_stemp;
            soe_b_ff <= nxt_soe_b;
            wake_ff  <= |in_s;
        end
    end
    assign sense_chan_o                = sch_ff;
    assign sense_temp_o                = stemp_ff;
    assign current_sense_output_oe_b_o = soe_b_ff;
    assign wake_o                      = wake_ff;
endmodule
`default_nettype wire

// *** tb/lsp_chk_sva.sv ***
/* Port assertions for lsp_ctrl.
   Bound to each instance; four channels are assumed. */
`default_nettype none
module lsp_chk (
    input wire logic        core_clk_i,
    input wire logic        rst_b_i,
    input wire logic [3:0]  direct_inputs_i,
    input wire logic        pwm_en_i,
    input wire logic        clock_sel_i,
    input wire logic [3:0]  pwm_sel_i,
    input wire logic [31:0] duty_i,
    input wire logic [2:0]  sense_src_i,
    input wire logic        sense_hiz_i,
    input wire logic [3:0]  high_side_outputs_o,
    input wire logic        clk_fail_o,
    input wire logic        wake_o,
    input wire logic [3:0]  sense_chan_o,
    input wire logic        sense_temp_o,
    input wire logic        current_sense_output_oe_b_o
);
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    sequence s_dir1;
        !pwm_sel_i[1] && direct_inputs_i[1];
    endsequence
    a_fail_disarm: assert property (
        !pwm_en_i || clock_sel_i |=> !clk_fail_o) else $error("fail");
    a_pwm_on: assert property (
        (pwm_en_i && pwm_sel_i[0] && duty_i[7:0] == 8'hFF) [*2]
        |-> high_side_outputs_o[0]) else $error("on");
    a_pwm_off: assert property (
        (pwm_en_i && pwm_sel_i[0] && duty_i[7:0] == 8'h00) [*2]
        |-> !high_side_outputs_o[0]) else $error("off");
    a_wake_any: assert property (
        (direct_inputs_i != 4'h0) [*5] |-> wake_o) else $error("wake");
    a_direct_drive: assert property (
        s_dir1 [*5] |-> high_side_outputs_o[1]) else $error("drive");
    a_sense_temp: assert property (
        sense_src_i == 3'h4 |=> sense_temp_o && sense_chan_o == 4'h0)
        else $error("temp");
    a_sense_chan: assert property (
        sense_src_i < 3'h4 |=> sense_chan_o == 4'h1 << $past(sense_src_i))
        else $error("chan");
    a_sense_hiz: assert property (
        1'b1 |=> current_sense_output_oe_b_o == $past(sense_hiz_i))
        else $error("hiz");
endmodule
bind lsp_ctrl lsp_chk i_chk (.*);
`default_nettype wire

// *** tb/lsp_host_model.sv ***
/* Host controller model: serial pins, calibration, direct inputs.
   Assumes the core clock's falling edge paces every pin change. */
`default_nettype none
module lsp_host_model (
    input  wire logic       clk_i,
    input  wire logic       so_i,
    output var  logic       sclk_o,
    output var  logic       cs_b_o,
    output var  logic       si_o,
    output var  logic [3:0] din_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {sclk_o, si_o, din_o} = '0;
        cs_b_o = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic set_in(input logic [3:0] v);
        din_o = v;
    endtask
    task automatic xfer(input logic [15:0] w, input int n,
                        output logic [15:0] r);
        r = 16'h0000;
        cs_b_o = 1'b0;
        wt(128);
        for (int i = 0; i < n; i++) begin
            si_o = w[15 - i];
            sclk_o = 1'b1;
            wt(16);
            r = {r[14:0], so_i};
            sclk_o = 1'b0;
            wt(16);
        end
        cs_b_o = 1'b1;
        si_o = 1'b0;
        wt(256);
    endtask
    task automatic cal(input int n);
        cs_b_o = 1'b0;
        wt(n);
        cs_b_o = 1'b1;
        wt(256);
    endtask
    task automatic ext(input int p, input int k);
        repeat (k) begin
            din_o[0] = 1'b1;
            wt(p / 2);
            din_o[0] = 1'b0;
            wt(p / 2);
        end
    endtask
endmodule
`default_nettype wire

// *** tb/test_lamp_switch_pwm_input_control.sv ***
/* Self-checking bench of the lamp switch control.
   Uses the host model for the pins; shortened counts. */
`default_nettype none
`define CHK(nm, e, a) begin \
    n_checks++; \
    if ((a) !== (e)) begin \
        n_errors++; \
        $display("[FAIL] %s exp %0h got %0h", nm, e, a); \
    end \
end
module test_lamp_switch_pwm_input_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_b, sclk, cs_b, si, so, so_oe_b, load;
    logic        en, csel, hiz, fail, cal_done, wake, stemp, soe_b;
    logic [3:0]  din, psel, hso, tog, schan;
    logic [2:0]  ssrc;
    logic [15:0] word, status, rx;
    logic [31:0] duty;
    int          n_errors, n_checks, n_load;
    lsp_ctrl #(.CAL_MIN_CYC(20), .CAL_MAX_CYC(200), .FAIL_SLOW_CYC(12000),
        .TOGGLE_CYC(1000), .DEF_TICK_CYC(8)) i_dut (
        .core_clk_i(clk), .rst_b_i(rst_b), .direct_inputs_i(din),
        .spi_sclk_i(sclk), .spi_cs_b_i(cs_b), .spi_si_i(si), .spi_so_o(so),
        .spi_so_oe_b_o(so_oe_b), .spi_word_o(word), .spi_load_o(load),
        .status_i(status), .pwm_en_i(en), .clock_sel_i(csel),
        .pwm_sel_i(psel), .duty_i(duty), .sense_src_i(ssrc),
        .sense_hiz_i(hiz), .high_side_outputs_o(hso), .clk_fail_o(fail),
        .cal_done_o(cal_done), .toggling_o(tog), .wake_o(wake),
        .sense_chan_o(schan), .sense_temp_o(stemp),
        .current_sense_output_oe_b_o(soe_b));
    lsp_host_model i_host (.clk_i(clk), .so_i(so), .sclk_o(sclk),
        .cs_b_o(cs_b), .si_o(si), .din_o(din));
    initial clk = 1'b0;
    always #2 clk = ~clk;
    always @(posedge clk) if (load === 1'b1) n_load++;
    task automatic conclude();
        if (n_errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic t_per(input int p);
        int c;
        c = 0;
        @(posedge hso[0]);
        while (hso[0] === 1'b1) @(posedge clk) c++;
        while (hso[0] === 1'b0) @(posedge clk) c++;
        `CHK("period", 1'b1, c > p * 9 / 10 && c < p * 11 / 10)
        i_host.wt(1);
    endtask
    task automatic t_dir();
        for (int i = 0; i < 4; i++) begin
            i_host.set_in(4'h1 << i);
            i_host.wt(8);
            `CHK("direct", 4'h1 << i, hso)
            `CHK("wake", 1'b1, wake)
            `CHK("toggle", 1'b1, tog[i])
        end
        i_host.set_in(4'h0);
        i_host.wt(500);
        `CHK("wake off", 1'b0, wake)
        `CHK("toggle held", 1'b1, tog[3])
        i_host.wt(600);
        `CHK("toggle off", 4'h0, tog)
    endtask
    task automatic t_spi();
        int n;
        n = n_load;
        i_host.xfer(16'h3C5A, 16, rx);
        `CHK("word", 16'h3C5A, word)
        `CHK("status out", status, rx)
        `CHK("loads", n + 1, n_load)
        `CHK("so released", 1'b1, so_oe_b)
        status = 16'h5A3C;
        i_host.xfer(16'hFFFF, 8, rx);
        `CHK("short status", 8'h5A, rx[7:0])
        `CHK("short word", 16'h3C5A, word)
        `CHK("short loads", n + 1, n_load)
    endtask
    task automatic t_pwm();
        {en, csel, psel} = 6'h3F;
        t_per(2048);
        i_host.cal(12);
        i_host.cal(300);
        `CHK("cal refused", 1'b0, cal_done)
        i_host.cal(100);
        `CHK("cal done", 1'b1, cal_done)
        t_per(3072);
        duty = {4{8'hFF}};
        i_host.wt(4);
        `CHK("full on", 4'hF, hso)
        psel = 4'h5;
        i_host.set_in(4'h2);
        i_host.wt(8);
        `CHK("mixed", 4'h7, hso)
        i_host.set_in(4'h0);
        psel = 4'hF;
        i_host.wt(8);
        duty = '0;
        i_host.wt(4);
        `CHK("full off", 4'h0, hso)
    endtask
    task automatic t_ext();
        duty = {4{8'h80}};
        csel = 1'b0;
        i_host.ext(5000, 3);
        `CHK("good clock", 1'b0, fail)
        i_host.ext(400, 4);
        `CHK("fast fail", 1'b1, fail)
        i_host.ext(5000, 3);
        `CHK("fail clears", 1'b0, fail)
        i_host.wt(13000);
        `CHK("slow fail", 1'b1, fail)
        csel = 1'b1;
        i_host.wt(2);
        `CHK("disarmed", 1'b0, fail)
    endtask
    task automatic t_sense();
        for (int s = 0; s < 8; s++) begin
            ssrc = 3'(s);
            hiz = s[0];
            i_host.wt(2);
            `CHK("chan", s < 4 ? 4'h1 << s : 4'h0, schan)
            `CHK("temp", s == 4, stemp)
            `CHK("hiz", hiz, soe_b)
        end
    endtask
    task automatic t_rst();
        rst_b = 1'b0;
        i_host.wt(20);
        `CHK("rst outputs", 4'h0, hso)
        `CHK("rst cal", 1'b0, cal_done)
        `CHK("rst hiz", 1'b1, soe_b)
        rst_b = 1'b1;
        i_host.wt(3);
        `CHK("rst word", 16'h0000, word)
        `CHK("rst fail", 1'b0, fail)
    endtask
    initial begin
        rst_b = 1'b0;
        status = 16'hA5C3;
        {en, csel, hiz, psel, ssrc} = '0;
        duty = {4{8'h80}};
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        i_host.wt(1300);
        t_dir();
        t_spi();
        t_pwm();
        t_ext();
        t_sense();
        t_rst();
        conclude();
    end
    initial begin
        repeat (95000) @(posedge clk);
        n_errors++;
        conclude();
    end
endmodule
`default_nettype wire
